// ==== rtl/atl_regs.vh ====
// Constants for the arc trip decision block: register map, fields, timing counts.
// Assumes a 20 MHz aclk; all counts are derived from times in their own units.
`ifndef ATL_REGS_VH
`define ATL_REGS_VH

`define ATL_CLK_HZ 20000000
// Register byte offsets
`define ATL_OFF_CTRL 12'h000
`define ATL_OFF_STAT 12'h004
`define ATL_OFF_CFG 12'h008
`define ATL_OFF_SET 12'h00c
// Control fields
`define ATL_CTRL_MODE 0
`define ATL_CTRL_BO_LIGHT 1
`define ATL_CTRL_BI2_MT 2
`define ATL_CTRL_BREAKER_FAILURE_BACKUP_LONG 3
`define ATL_CTRL_FAST_OUT_ONE_EN 4
`define ATL_CTRL_BI1_OC 5
`define ATL_CTRL_RESET 32'h0000_0035
// Set register fields
`define ATL_SET_PRESS 0
`define ATL_SET_FAULT 1
// Times and derived cycle counts
`define ATL_POWERUP_MS 50
`define ATL_POWERUP_CYC (`ATL_POWERUP_MS * (`ATL_CLK_HZ / 1000))
`define ATL_BREAKER_FAILURE_BACKUP_SHORT_MS 100
`define ATL_BREAKER_FAILURE_BACKUP_LONG_MS 150
`define ATL_BREAKER_FAILURE_BACKUP_SHORT_CYC (`ATL_BREAKER_FAILURE_BACKUP_SHORT_MS * (`ATL_CLK_HZ / 1000))
`define ATL_BREAKER_FAILURE_BACKUP_LONG_CYC (`ATL_BREAKER_FAILURE_BACKUP_LONG_MS * (`ATL_CLK_HZ / 1000))
`define ATL_HOLD_MS 2000
`define ATL_HOLD_CYC (`ATL_HOLD_MS * (`ATL_CLK_HZ / 1000))
`define ATL_DEBOUNCE_MS 20
`define ATL_DEBOUNCE_CYC (`ATL_DEBOUNCE_MS * (`ATL_CLK_HZ / 1000))
`define ATL_PRESS_WIN_MS 1000
`define ATL_PRESS_WIN_CYC (`ATL_PRESS_WIN_MS * (`ATL_CLK_HZ / 1000))
`define ATL_BLINK_ON_MS 300
`define ATL_BLINK_ON_CYC (`ATL_BLINK_ON_MS * (`ATL_CLK_HZ / 1000))
`define ATL_BLINK_OFF_MS 300
`define ATL_BLINK_OFF_CYC (`ATL_BLINK_OFF_MS * (`ATL_CLK_HZ / 1000))
`define ATL_GAP_MS 1500
`define ATL_GAP_CYC (`ATL_GAP_MS * (`ATL_CLK_HZ / 1000))
`define ATL_SYNC_PERIOD_MS 10
`define ATL_SYNC_PERIOD_CYC (`ATL_SYNC_PERIOD_MS * (`ATL_CLK_HZ / 1000))
`define ATL_SYNC_US 50
`define ATL_SYNC_CYC (`ATL_SYNC_US * (`ATL_CLK_HZ / 1000000))

`endif

// ==== rtl/atl_trip.v ====
// Arc trip decision, breaker failure backup, set-button handling and connection self-check.
// Assumes synchronous, debounced-free raw inputs on aclk and an AXI4-Lite master for setup.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "atl_regs.vh"

module atl_trip #(
  parameter POWERUP_CYC = `ATL_POWERUP_CYC,
  parameter BREAKER_FAILURE_BACKUP_SHORT_CYC = `ATL_BREAKER_FAILURE_BACKUP_SHORT_CYC,
  parameter BREAKER_FAILURE_BACKUP_LONG_CYC = `ATL_BREAKER_FAILURE_BACKUP_LONG_CYC,
  parameter HOLD_CYC = `ATL_HOLD_CYC,
  parameter DEBOUNCE_CYC = `ATL_DEBOUNCE_CYC,
  parameter PRESS_WIN_CYC = `ATL_PRESS_WIN_CYC,
  parameter BLINK_ON_CYC = `ATL_BLINK_ON_CYC,
  parameter BLINK_OFF_CYC = `ATL_BLINK_OFF_CYC,
  parameter GAP_CYC = `ATL_GAP_CYC,
  parameter SYNC_PERIOD_CYC = `ATL_SYNC_PERIOD_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] light_in,
  input wire overcurrent_in,
  input wire aux_light_master_in,
  input wire set_button,
  input wire fault_in,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg trip_relay_one,
  output reg trip_relay_backup,
  output reg fast_out_one,
  output reg fast_out_sync,
  output reg signal_out,
  output reg optical_port,
  output reg system_failure_relay,
  output reg [3:0] channel_led,
  output reg bi1_led,
  output reg bi2_led,
  output reg trip_led,
  output reg backup_led,
  output reg error_led
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ON = 2'd1;
  localparam ST_OFF = 2'd2;
  localparam ST_GAP = 2'd3;

  reg [31:0] ctrl_q;
  reg [1:0] cnt_q [0:5];
  reg [7:0] sw_set_q;
  reg [22:0] pwr_cnt_q;
  reg prot_on_q;
  reg [22:0] breaker_failure_backup_cnt_q;
  reg breaker_failure_backup_q;
  reg [3:0] ch_lat_q;
  reg bi1_lat_q, bi2_lat_q, trip_lat_q, bk_lat_q;
  reg [17:0] sync_cnt_q;
  reg [19:0] deb_cnt_q;
  reg btn_q;
  reg btn_prev_q;
  reg [25:0] hold_cnt_q;
  reg hold_done_q;
  reg [24:0] win_cnt_q;
  reg [1:0] press_cnt_q;
  reg [1:0] sc_state_q;
  reg [2:0] sc_idx_q;
  reg [1:0] sc_blinks_q;
  reg [24:0] sc_tmr_q;
  reg sc_led_q;
  reg aw_hold_q, w_hold_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [1:0] sense_q [0:3];
  integer k;
  integer j;

  // Auto-configuration stores channel sensor counts saturated at 3; sense_q never leaves zero, so each stores 0
  function [1:0] sat2;
    input [2:0] v;
    begin
      sat2 = (v > 3'd3) ? 2'd3 : v[1:0];
    end
  endfunction

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a[11:2] == off[11:2]);
    end
  endfunction

  wire mode_lc = ctrl_q[`ATL_CTRL_MODE];
  wire bo_light = ctrl_q[`ATL_CTRL_BO_LIGHT];
  wire bi2_mt = ctrl_q[`ATL_CTRL_BI2_MT];
  wire bi1_oc = ctrl_q[`ATL_CTRL_BI1_OC];
  wire any_light = |light_in;
  // Input one either carries over-current or extra light from a neighbour
  wire bi1_light = ~bi1_oc & overcurrent_in;
  wire oc_ok = bi1_oc & overcurrent_in;
  wire light_all = any_light | bi1_light | (~bi2_mt & aux_light_master_in);
  wire master = bi2_mt & aux_light_master_in;
  wire trip_now = prot_on_q & (master | (mode_lc ? (light_all & oc_ok) : light_all));
  wire [22:0] breaker_failure_backup_lim = ctrl_q[`ATL_CTRL_BREAKER_FAILURE_BACKUP_LONG] ? BREAKER_FAILURE_BACKUP_LONG_CYC[22:0] : BREAKER_FAILURE_BACKUP_SHORT_CYC[22:0];
  wire press_edge = btn_q & ~btn_prev_q;
  wire release_edge = ~btn_q & btn_prev_q;
  wire short_press = release_edge & ~hold_done_q;
  wire clear_latch = short_press | sw_set_q[`ATL_SET_PRESS];
  wire start_sc = short_press & (press_cnt_q == 2'd2) & (sc_state_q == ST_IDLE);
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  // Power-up hold-off and protection enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      pwr_cnt_q <= 23'd0;
      prot_on_q <= 1'b0;
    end else if (!prot_on_q) begin
      pwr_cnt_q <= pwr_cnt_q + 23'd1;
      if (pwr_cnt_q == POWERUP_CYC[22:0] - 23'd1)
        prot_on_q <= 1'b1;
    end
  end

  // Breaker failure timer runs while trip criteria persist
  always @(posedge aclk) begin
    if (!aresetn) begin
      breaker_failure_backup_cnt_q <= 23'd0;
      breaker_failure_backup_q <= 1'b0;
    end else if (trip_now) begin
      if (breaker_failure_backup_cnt_q < breaker_failure_backup_lim)
        breaker_failure_backup_cnt_q <= breaker_failure_backup_cnt_q + 23'd1;
      else
        breaker_failure_backup_q <= 1'b1;
    end else begin
      breaker_failure_backup_cnt_q <= 23'd0;
      breaker_failure_backup_q <= 1'b0;
    end
  end

  // Latched indications; a new event wins over a simultaneous clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      ch_lat_q <= 4'h0;
      bi1_lat_q <= 1'b0;
      bi2_lat_q <= 1'b0;
      trip_lat_q <= 1'b0;
      bk_lat_q <= 1'b0;
    end else begin
      ch_lat_q <= (clear_latch ? 4'h0 : ch_lat_q) | (prot_on_q ? light_in : 4'h0);
      bi1_lat_q <= (~clear_latch & bi1_lat_q) | (prot_on_q & overcurrent_in);
      bi2_lat_q <= (~clear_latch & bi2_lat_q) | (prot_on_q & aux_light_master_in);
      trip_lat_q <= (~clear_latch & trip_lat_q) | trip_now;
      bk_lat_q <= (~clear_latch & bk_lat_q) | breaker_failure_backup_q;
    end
  end

  // Sync pulse on second fast output; trip is ORed in and dominates
  always @(posedge aclk) begin
    if (!aresetn)
      sync_cnt_q <= 18'd0;
    else if (sync_cnt_q == SYNC_PERIOD_CYC[17:0] - 18'd1)
      sync_cnt_q <= 18'd0;
    else
      sync_cnt_q <= sync_cnt_q + 18'd1;
  end

  // Outputs straight from flip-flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      trip_relay_one <= 1'b0;
      trip_relay_backup <= 1'b0;
      fast_out_one <= 1'b0;
      fast_out_sync <= 1'b0;
      signal_out <= 1'b0;
      optical_port <= 1'b0;
      system_failure_relay <= 1'b0;
      channel_led <= 4'h0;
      bi1_led <= 1'b0;
      bi2_led <= 1'b0;
      trip_led <= 1'b0;
      backup_led <= 1'b0;
      error_led <= 1'b0;
    end else begin
      trip_relay_one <= trip_lat_q | trip_now;
      trip_relay_backup <= bk_lat_q | breaker_failure_backup_q;
      fast_out_one <= ctrl_q[`ATL_CTRL_FAST_OUT_ONE_EN] & (trip_lat_q | trip_now);
      fast_out_sync <= trip_lat_q | trip_now |
                       (prot_on_q & (sync_cnt_q < `ATL_SYNC_CYC));
      // Follows the source live, no latch
      signal_out <= (bo_light & prot_on_q & light_all) | breaker_failure_backup_q;
      optical_port <= prot_on_q;
      system_failure_relay <= prot_on_q & ~fault_in & ~sw_set_q[`ATL_SET_FAULT];
      error_led <= fault_in | sw_set_q[`ATL_SET_FAULT];
      // Self-check blink overrides the one LED under test only
      for (k = 0; k < 4; k = k + 1)
        channel_led[k] <= (sc_state_q != ST_IDLE && sc_idx_q == k) ? sc_led_q : ch_lat_q[k];
      bi1_led <= (sc_state_q != ST_IDLE && sc_idx_q == 3'd4) ? sc_led_q : bi1_lat_q;
      bi2_led <= (sc_state_q != ST_IDLE && sc_idx_q == 3'd5) ? sc_led_q : bi2_lat_q;
      trip_led <= trip_lat_q | trip_now;
      backup_led <= bk_lat_q | breaker_failure_backup_q;
    end
  end

  // Button debounce, hold detection and quick-press counting
  always @(posedge aclk) begin
    if (!aresetn) begin
      deb_cnt_q <= 20'd0;
      btn_q <= 1'b0;
      btn_prev_q <= 1'b0;
      hold_cnt_q <= 26'd0;
      hold_done_q <= 1'b0;
      win_cnt_q <= 25'd0;
      press_cnt_q <= 2'd0;
    end else begin
      btn_prev_q <= btn_q;
      if (set_button == btn_q)
        deb_cnt_q <= 20'd0;
      else if (deb_cnt_q == DEBOUNCE_CYC[19:0] - 20'd1) begin
        deb_cnt_q <= 20'd0;
        btn_q <= set_button;
      end else
        deb_cnt_q <= deb_cnt_q + 20'd1;
      if (!btn_q) begin
        hold_cnt_q <= 26'd0;
        hold_done_q <= 1'b0;
      end else if (hold_cnt_q == HOLD_CYC[25:0] - 26'd1)
        hold_done_q <= 1'b1;
      else
        hold_cnt_q <= hold_cnt_q + 26'd1;
      if (press_edge && press_cnt_q == 2'd0)
        win_cnt_q <= 25'd0;
      else if (win_cnt_q != PRESS_WIN_CYC[24:0])
        win_cnt_q <= win_cnt_q + 25'd1;
      if (start_sc || win_cnt_q == PRESS_WIN_CYC[24:0] || hold_done_q)
        press_cnt_q <= 2'd0;
      else if (short_press && press_cnt_q != 2'd3)
        press_cnt_q <= press_cnt_q + 2'd1;
    end
  end

  // Auto-configuration stores the counted device numbers at the end of a hold
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < 6; j = j + 1)
        cnt_q[j] <= 2'd0;
      for (j = 0; j < 4; j = j + 1)
        sense_q[j] <= 2'd0;
    end else if (btn_q && hold_cnt_q == HOLD_CYC[25:0] - 26'd1 && !hold_done_q) begin
      for (j = 0; j < 4; j = j + 1)
        cnt_q[j] <= sat2({1'b0, sense_q[j]});
      cnt_q[4] <= {1'b0, overcurrent_in};
      cnt_q[5] <= {1'b0, aux_light_master_in};
    end else if (sw_set_q[`ATL_SET_PRESS]) begin
      for (j = 0; j < 4; j = j + 1)
        sense_q[j] <= sense_q[j];
    end
  end

  // Self-check walks six inputs; protection path is untouched
  always @(posedge aclk) begin
    if (!aresetn) begin
      sc_state_q <= ST_IDLE;
      sc_idx_q <= 3'd0;
      sc_blinks_q <= 2'd0;
      sc_tmr_q <= 25'd0;
      sc_led_q <= 1'b0;
    end else begin
      case (sc_state_q)
        ST_IDLE: begin
          sc_led_q <= 1'b0;
          if (start_sc) begin
            sc_idx_q <= 3'd0;
            sc_blinks_q <= cnt_q[0];
            sc_tmr_q <= 25'd0;
            sc_state_q <= (cnt_q[0] != 2'd0) ? ST_ON : ST_GAP;
          end
        end
        ST_ON: begin
          sc_led_q <= 1'b1;
          sc_tmr_q <= sc_tmr_q + 25'd1;
          if (sc_tmr_q == BLINK_ON_CYC[24:0] - 25'd1) begin
            sc_tmr_q <= 25'd0;
            sc_blinks_q <= sc_blinks_q - 2'd1;
            sc_state_q <= ST_OFF;
          end
        end
        ST_OFF: begin
          sc_led_q <= 1'b0;
          sc_tmr_q <= sc_tmr_q + 25'd1;
          if (sc_tmr_q == BLINK_OFF_CYC[24:0] - 25'd1) begin
            sc_tmr_q <= 25'd0;
            sc_state_q <= (sc_blinks_q != 2'd0) ? ST_ON : ST_GAP;
          end
        end
        default: begin
          sc_led_q <= 1'b0;
          sc_tmr_q <= sc_tmr_q + 25'd1;
          if (sc_tmr_q == GAP_CYC[24:0] - 25'd1) begin
            sc_tmr_q <= 25'd0;
            if (sc_idx_q == 3'd5)
              sc_state_q <= ST_IDLE;
            else begin
              sc_idx_q <= sc_idx_q + 3'd1;
              sc_blinks_q <= cnt_q[sc_idx_q + 3'd1];
              sc_state_q <= (cnt_q[sc_idx_q + 3'd1] != 2'd0) ? ST_ON : ST_GAP;
            end
          end
        end
      endcase
    end
  end

  // AXI4-Lite slave: one write and one read outstanding, addresses and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= `ATL_CTRL_RESET;
      sw_set_q <= 8'h00;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
      sw_set_q[`ATL_SET_PRESS] <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (is_addr(awaddr_q, `ATL_OFF_CTRL)) begin
          if (wstrb_q[0])
            ctrl_q[7:0] <= wdata_q[7:0];
        end else if (is_addr(awaddr_q, `ATL_OFF_SET)) begin
          if (wstrb_q[0])
            sw_set_q <= wdata_q[7:0];
        end else if (!is_addr(awaddr_q, `ATL_OFF_STAT) && !is_addr(awaddr_q, `ATL_OFF_CFG))
          s_axi_bresp <= 2'b10;
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (is_addr(s_axi_araddr, `ATL_OFF_CTRL))
          s_axi_rdata <= {24'h000000, ctrl_q[7:0]};
        else if (is_addr(s_axi_araddr, `ATL_OFF_STAT))
          s_axi_rdata <= {16'h0000, 1'b0, sc_state_q != ST_IDLE, prot_on_q, breaker_failure_backup_q,
                          trip_lat_q, bk_lat_q, bi2_lat_q, bi1_lat_q, 4'h0, ch_lat_q};
        else if (is_addr(s_axi_araddr, `ATL_OFF_CFG))
          s_axi_rdata <= {20'h00000, cnt_q[5], cnt_q[4], cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
        else if (is_addr(s_axi_araddr, `ATL_OFF_SET))
          s_axi_rdata <= {24'h000000, sw_set_q};
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== bench/atl_trip_chk.sv ====
// Port-level checker for the arc trip block.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/1ps
module atl_trip_chk #(
  parameter POWERUP_CYC = 20
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] light_in,
  input wire fault_in,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire trip_relay_one,
  input wire trip_relay_backup,
  input wire fast_out_sync,
  input wire signal_out,
  input wire optical_port,
  input wire system_failure_relay,
  input wire [3:0] channel_led,
  input wire error_led
);
  integer up_cnt_q;
  always @(posedge aclk) begin
    if (!aresetn)
      up_cnt_q <= 0;
    else if (up_cnt_q < POWERUP_CYC + 8)
      up_cnt_q <= up_cnt_q + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> !trip_relay_one && !optical_port && !system_failure_relay)
    else $error("output active at reset release");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped before bready");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before rready");
  a_powerup_live: assert property (up_cnt_q >= POWERUP_CYC + 4 |-> optical_port)
    else $error("optical port not lit after power-up time");
  a_led_follows: assert property (optical_port && light_in[0] |-> ##[1:3] channel_led[0])
    else $error("channel LED missed light");
  a_sync_keeps_trip: assert property (trip_relay_one |-> ##[0:1] fast_out_sync)
    else $error("sync output masks trip");
  a_backup_cause: assert property ($rose(trip_relay_backup) |-> $past(trip_relay_one, 8) && signal_out)
    else $error("backup trip without sustained trip");
  a_fault_flag: assert property (optical_port && fault_in |-> ##[1:3] (!system_failure_relay && error_led))
    else $error("fault not indicated");
  c_backup: cover property ($rose(trip_relay_backup));
  c_fault: cover property ($rose(error_led));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== bench/atl_field.sv ====
// Far side: four sensor channels, neighbour lines and the breaker opened by trip one.
// Assumes the bench changes its commands just after rising aclk edges.
`timescale 1ns/1ps
module atl_field #(
  parameter BRK_CYC = 3
) (
  input wire aclk,
  input wire [3:0] arc_cmd,
  input wire oc_cmd,
  input wire mt_cmd,
  input wire brk_stuck,
  input wire trip_relay_one,
  output reg [3:0] light_in = 4'h0,
  output reg overcurrent_in = 1'b0,
  output reg aux_light_master_in = 1'b0
);
  integer brk_cnt_q = 0;
  reg brk_open_q = 1'b0;
  always @(posedge aclk) begin
    if (arc_cmd == 4'h0) begin
      brk_open_q <= 1'b0;
      brk_cnt_q <= 0;
    end else if (trip_relay_one && !brk_stuck) begin
      if (brk_cnt_q == BRK_CYC)
        brk_open_q <= 1'b1;
      else
        brk_cnt_q <= brk_cnt_q + 1;
    end
    // Chained sensors on a channel merge into one level; an open breaker ends the arc
    light_in <= brk_open_q ? 4'h0 : arc_cmd;
    overcurrent_in <= oc_cmd & !brk_open_q;
    aux_light_master_in <= mt_cmd;
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the arc trip block with the field model on its pins.
// Assumes shortened timing parameters; registers reached over AXI4-Lite.
`timescale 1ns/1ps
`include "atl_regs.vh"
module testbench;
  localparam int CBS = 10;
  localparam int CBL = 15;
  localparam int PWR = 20;
  localparam int HLD = 200;
  localparam int DEB = 4;
  localparam int WIN = 100;
  localparam int BLK = 5;
  localparam int GPC = 10;
  localparam int SYP = 2000;
  reg aclk = 1'b0, aresetn = 1'b0, set_button = 1'b0, fault_in = 1'b0;
  reg [3:0] arc_cmd = 4'h0;
  reg oc_cmd = 1'b0, mt_cmd = 1'b0, brk_stuck = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] light_in, channel_led;
  wire overcurrent_in, aux_light_master_in, trip_relay_one, trip_relay_backup, fast_out_one, fast_out_sync;
  wire signal_out, optical_port, system_failure_relay, bi1_led, bi2_led, trip_led, backup_led, error_led;
  integer mismatches = 0, checks_done = 0;
  always #25 aclk = ~aclk;
  atl_field fld_u (.aclk, .arc_cmd, .oc_cmd, .mt_cmd, .brk_stuck, .trip_relay_one, .light_in, .overcurrent_in,
    .aux_light_master_in);
  atl_trip #(.POWERUP_CYC(PWR), .BREAKER_FAILURE_BACKUP_SHORT_CYC(CBS), .BREAKER_FAILURE_BACKUP_LONG_CYC(CBL), .HOLD_CYC(HLD), .DEBOUNCE_CYC(DEB),
    .PRESS_WIN_CYC(WIN), .BLINK_ON_CYC(BLK), .BLINK_OFF_CYC(BLK), .GAP_CYC(GPC), .SYNC_PERIOD_CYC(SYP)) dut_u (
    .aclk, .aresetn, .light_in, .overcurrent_in, .aux_light_master_in, .set_button, .fault_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trip_relay_one, .trip_relay_backup, .fast_out_one,
    .fast_out_sync, .signal_out, .optical_port, .system_failure_relay, .channel_led, .bi1_led, .bi2_led,
    .trip_led, .backup_led, .error_led);

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic set_press();
    axi_wr(`ATL_OFF_SET, 32'h1, 2'h0);
    cyc(3);
  endtask
  task automatic press(input int n);
    @(posedge aclk) set_button <= 1'b1;
    cyc(n);
    set_button <= 1'b0;
    cyc(8);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk("optical", 1, optical_port);
    chk("sf_relay", 1, system_failure_relay);
    axi_rd(`ATL_OFF_CTRL, d, r);
    chk("ctrl_reset", `ATL_CTRL_RESET, d);
    axi_wr(12'h010, 32'h0, 2'h2);
    axi_rd(12'h010, d, r);
    chk("rresp", 2'h2, r);
    chk("rdata", 32'h0, d);
    axi_wr(`ATL_OFF_STAT, 32'hffff_ffff, 2'h0);
  endtask
  task automatic t_light_no_oc();
    axi_wr(`ATL_OFF_CTRL, 32'h37, 2'h0);
    @(posedge aclk) arc_cmd <= 4'h2;
    cyc(5);
    chk("trip1", 0, trip_relay_one);
    chk("trip_led", 0, trip_led);
    chk("ch_led", 4'h2, channel_led);
    chk("sig_out", 1, signal_out);
    arc_cmd <= 4'h0;
    cyc(5);
    chk("sig_out", 0, signal_out);
    set_press();
    chk("ch_led", 4'h0, channel_led);
  endtask
  task automatic t_light_oc();
    @(posedge aclk) arc_cmd <= 4'h4;
    oc_cmd <= 1'b1;
    cyc(5);
    chk("trip1", 1, trip_relay_one);
    chk("fast1", 1, fast_out_one);
    chk("leds", 6'h34, {trip_led, bi1_led, channel_led});
    cyc(CBS + 6);
    chk("trip2", 0, trip_relay_backup);
    arc_cmd <= 4'h0;
    oc_cmd <= 1'b0;
    set_press();
    chk("trip1", 0, trip_relay_one);
  endtask
  task automatic t_light_only();
    axi_wr(`ATL_OFF_CTRL, 32'h34, 2'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk) arc_cmd <= 4'h1 << k;
      cyc(5);
      chk("ch_led", 4'h1 << k, channel_led);
      chk("trips", 3'h7, {trip_relay_one, fast_out_one, trip_led});
      arc_cmd <= 4'h0;
      set_press();
    end
  endtask
  task automatic t_master();
    @(posedge aclk) mt_cmd <= 1'b1;
    cyc(5);
    chk("mt_trip", 3'h7, {trip_relay_one, trip_led, bi2_led});
    mt_cmd <= 1'b0;
    set_press();
    // Input one switched to carry neighbour light instead of over-current
    axi_wr(`ATL_OFF_CTRL, 32'h10, 2'h0);
    @(posedge aclk) oc_cmd <= 1'b1;
    cyc(5);
    chk("bi1_light", 3'h7, {trip_relay_one, bi1_led, fast_out_one});
    oc_cmd <= 1'b0;
    set_press();
  endtask
  task automatic t_breaker_failure_backup();
    for (int lng = 0; lng < 2; lng++) begin
      axi_wr(`ATL_OFF_CTRL, 32'h34 | (lng << 3), 2'h0);
      @(posedge aclk) brk_stuck <= 1'b1;
      arc_cmd <= 4'h1;
      cyc(lng ? CBL : CBS);
      chk("trip2_early", 0, trip_relay_backup);
      cyc(6);
      chk("backup", 3'h7, {trip_relay_backup, backup_led, signal_out});
      arc_cmd <= 4'h0;
      brk_stuck <= 1'b0;
      cyc(5);
      chk("sig_out", 0, signal_out);
      set_press();
      chk("trip2", 0, trip_relay_backup);
    end
  endtask
  task automatic t_button();
    logic [31:0] d;
    logic [1:0] r;
    int n = 0;
    logic p = 1'b0;
    axi_wr(`ATL_OFF_CTRL, `ATL_CTRL_RESET, 2'h0);
    @(posedge aclk) oc_cmd <= 1'b1;
    press(220);
    oc_cmd <= 1'b0;
    axi_rd(`ATL_OFF_CFG, d, r);
    chk("cfg", 12'h100, d[11:0]);
    // Presses spread wider than the window must not start the check
    press(8); cyc(60); press(8); cyc(60); press(8);
    axi_rd(`ATL_OFF_STAT, d, r);
    chk("busy_slow", 0, d[14]);
    cyc(120);
    press(8); press(8); press(8);
    axi_rd(`ATL_OFF_STAT, d, r);
    chk("busy", 1, d[14]);
    @(posedge aclk) mt_cmd <= 1'b1;
    cyc(5);
    chk("trip_in_check", 1, trip_relay_one);
    mt_cmd <= 1'b0;
    repeat (400) begin
      @(posedge aclk);
      if (bi1_led && !p) n++;
      p = bi1_led;
    end
    chk("bi1_blinks", 1, n);
    axi_rd(`ATL_OFF_STAT, d, r);
    chk("busy_end", 0, d[14]);
    set_press();
  endtask
  task automatic t_fault();
    @(posedge aclk) fault_in <= 1'b1;
    cyc(5);
    chk("fault", 2'h1, {system_failure_relay, error_led});
    fault_in <= 1'b0;
    cyc(5);
    chk("healed", 2'h2, {system_failure_relay, error_led});
  endtask
  task automatic t_sync();
    int n = 0;
    int m = 0;
    while (fast_out_sync) @(posedge aclk);
    while (!fast_out_sync) @(posedge aclk);
    while (fast_out_sync) begin
      @(posedge aclk);
      n++;
    end
    while (!fast_out_sync) begin
      @(posedge aclk);
      m++;
    end
    chk("sync_high", `ATL_SYNC_CYC, n);
    chk("sync_period", SYP, n + m);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    cyc(16);
    aresetn <= 1'b1;
    cyc(30);
    t_regs();
    t_light_no_oc();
    t_light_oc();
    t_light_only();
    t_master();
    t_breaker_failure_backup();
    t_button();
    t_fault();
    t_sync();
    wrap_up();
  end
  initial begin
    // Slowest path is the sync measurement, two periods of 2000 cycles
    cyc(20000);
    mismatches++;
    wrap_up();
  end
endmodule

bind atl_trip atl_trip_chk #(.POWERUP_CYC(POWERUP_CYC)) chk_u (.aclk, .aresetn, .light_in, .fault_in,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .trip_relay_one,
  .trip_relay_backup, .fast_out_sync, .signal_out, .optical_port, .system_failure_relay, .channel_led, .error_led);
